// ---- verilog/config_access_router_defs.svh ----
`ifndef CONFIG_ACCESS_ROUTER_DEFS_SVH
`define CONFIG_ACCESS_ROUTER_DEFS_SVH

// I/O byte addresses of the index/data pair
`define IO_INDEX_ADDR   32'h0000_0cf8
`define IO_DATA_ADDR    32'h0000_0cfc
`define IO_DW_MASK      32'hffff_fffc
// index register layout and reset
`define IDX_RESET       32'h0000_0000
`define IDX_WMASK       32'h80ff_fffc
`define IDX_EN_BIT      31
`define IDX_BUS_HI      23
`define IDX_BUS_LO      16
`define IDX_DEV_HI      15
`define IDX_DEV_LO      11
`define IDX_FUNC_HI     10
`define IDX_FUNC_LO     8
`define IDX_REG_HI      7
`define IDX_REG_LO      2
// memory window address layout
`define MM_ADDR_HI      31
`define MM_BUS_HI       27
`define MM_BASE256_LO   28
`define MM_BASE128_LO   27
`define MM_BASE64_LO    26
`define MM_BUS_LO       20
`define MM_DEV_HI       19
`define MM_DEV_LO       15
`define MM_FUNC_HI      14
`define MM_FUNC_LO      12
`define MM_EXT_HI       11
`define MM_EXT_LO       8
`define MM_REG_HI       7
`define MM_REG_LO       2
// window size select encodings
`define MM_SIZE_256     2'h0
`define MM_SIZE_128     2'h1
`define MM_SIZE_64      2'h2
// byte enables and fixed values
`define BE_ALL          4'hf
`define EXT_ZERO        4'h0
`define BUS_ZERO        8'h00
`define DEV_ZERO        5'h00
`define INT_DEV_LIMIT   5'h04
`define RDATA_FLOAT     32'hffff_ffff
`define RDATA_ZERO      32'h0000_0000
`define HDR_RSVD4       4'h0
`define HDR_RSVD2       2'h0

`endif

// ---- verilog/config_access_router_pkg.sv ----
`include "config_access_router_defs.svh"

package config_access_router_pkg;

  // host processor bus request
  typedef struct packed {
    logic        valid;   // request present
    logic        io;      // 1 = I/O space, 0 = memory space
    logic        write;   // 1 = write
    logic        lock;    // locked transaction
    logic [31:0] addr;    // byte address
    logic [3:0]  be;      // byte enables
    logic [31:0] wdata;   // write data
  } host_req_type;

  // host processor bus answer
  typedef struct packed {
    logic        done;    // one-cycle completion
    logic        claimed; // access decoded by this block
    logic        abort;   // master abort / unsupported
    logic [31:0] rdata;   // read data
  } host_rsp_type;

  // translated configuration request
  typedef struct packed {
    logic        valid;   // held until completion
    logic        write;   // configuration write
    logic        type1;   // type 1 packet
    logic [7:0]  bus;     // bus number
    logic [4:0]  dev;     // device number
    logic [2:0]  func;    // function number
    logic [3:0]  ext;     // extended register index
    logic [5:0]  regnum;  // dword register number
    logic [3:0]  be;      // byte enables
    logic [31:0] wdata;   // write data
    logic [31:0] hdr;     // header bytes 8..11, byte 8 in [31:24]
  } cfg_req_type;

  // completion from a target
  typedef struct packed {
    logic        valid;   // one-cycle completion
    logic        abort;   // unsupported / unclaimed
    logic [31:0] rdata;   // read data
  } cfg_cpl_type;

  // destination of a request
  typedef enum logic [1:0] {
    DEST_INT,
    DEST_HUB,
    DEST_GFX
  } dest_type;

endpackage

// ---- verilog/config_access_router.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "config_access_router_defs.svh"

module config_access_router
  import config_access_router_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire host_req_type host_req,
  output logic              host_req_ready,
  output host_rsp_type      host_rsp,
  input  wire logic         mmcfg_enable,
  input  wire logic [31:26] mmcfg_window_base,
  input  wire logic [1:0]   mmcfg_size_sel,
  input  wire logic [7:0]   gfx_secondary_bus,
  input  wire logic [7:0]   gfx_subordinate_bus,
  input  wire logic [3:0]   int_dev_enable,
  output cfg_req_type       int_req,
  input  wire cfg_cpl_type  int_cpl,
  output cfg_req_type       hub_link_req,
  input  wire cfg_cpl_type  hub_link_cpl,
  output cfg_req_type       gfx_link_req,
  input  wire cfg_cpl_type  gfx_link_cpl
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // idle takes a request, wait holds a routed cycle until its target
  // completes, done presents the answer for exactly one cycle
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } state_type;

  state_type    state_r,  state_nxt;   // sequencer state
  logic [31:0]  index_r,  index_nxt;   // configuration index register
  cfg_req_type  creq_r,   creq_nxt;    // outstanding config request
  dest_type     dest_r,   dest_nxt;    // where it went
  host_rsp_type rsp_r,    rsp_nxt;     // answer being returned

  ////////////////////////////////////////////////////////////////////////////
  // address decode of the incoming request

  // decode runs every cycle on the raw request; its results matter
  // only while the sequencer is idle and a request is valid
  logic        io_dw_index;   // full dword access to the index
  logic        io_hit_index;  // any access in the index range
  logic        io_hit_data;   // any access in the data window
  logic        mm_hit;        // access inside the enabled window
  logic [7:0]  mm_bus;        // bus number from a window address
  cfg_req_type io_cfg;        // request built from the index
  cfg_req_type mm_cfg;        // request built from the window
  cfg_req_type sel_cfg;       // request chosen for routing
  dest_type    sel_dest;      // routing decision
  logic        sel_abort;     // decoded as a master abort

  // builds header bytes 8..11 from the request fields
  // reserved bits of bytes 10 and 11 always go out as zero
  function automatic logic [31:0] build_hdr(input cfg_req_type c);
    build_hdr = {c.bus,
                 c.dev, c.func,
                 `HDR_RSVD4, c.ext,
                 c.regnum, `HDR_RSVD2};
  endfunction

  // I/O decode of the index and data pair
  always_comb begin
    io_hit_index = host_req.io &&
                   ((host_req.addr & `IO_DW_MASK) == `IO_INDEX_ADDR);
    io_hit_data  = host_req.io &&
                   ((host_req.addr & `IO_DW_MASK) == `IO_DATA_ADDR);
    // byte or word references to the index are not taken as index loads
    io_dw_index  = io_hit_index && (host_req.be == `BE_ALL);
  end

  // request from the index register, compatible region only
  // the index cannot name the extended region, so ext stays zero
  always_comb begin
    io_cfg        = '0;
    io_cfg.valid  = 1'b1;
    io_cfg.write  = host_req.write;
    io_cfg.bus    = index_r[`IDX_BUS_HI:`IDX_BUS_LO];
    io_cfg.dev    = index_r[`IDX_DEV_HI:`IDX_DEV_LO];
    io_cfg.func   = index_r[`IDX_FUNC_HI:`IDX_FUNC_LO];
    io_cfg.ext    = `EXT_ZERO;
    io_cfg.regnum = index_r[`IDX_REG_HI:`IDX_REG_LO];
    io_cfg.be     = host_req.be;
    io_cfg.wdata  = host_req.wdata;
  end

  // memory window decode by size select
  always_comb begin
    mm_hit = 1'b0;
    mm_bus = host_req.addr[`MM_BUS_HI:`MM_BUS_LO];
    case (mmcfg_size_sel)
      `MM_SIZE_256: begin
        // every bus number reachable
        mm_hit = host_req.addr[`MM_ADDR_HI:`MM_BASE256_LO] ==
                 mmcfg_window_base[`MM_ADDR_HI:`MM_BASE256_LO];
      end
      `MM_SIZE_128: begin
        // upper half of the bus range falls outside the window
        mm_hit = host_req.addr[`MM_ADDR_HI:`MM_BASE128_LO] ==
                 mmcfg_window_base[`MM_ADDR_HI:`MM_BASE128_LO];
        mm_bus = {1'b0, host_req.addr[`MM_BASE128_LO-1:`MM_BUS_LO]};
      end
      `MM_SIZE_64: begin
        // only the lowest quarter of bus numbers reachable
        mm_hit = host_req.addr[`MM_ADDR_HI:`MM_BASE64_LO] ==
                 mmcfg_window_base[`MM_ADDR_HI:`MM_BASE64_LO];
        mm_bus = {2'b00, host_req.addr[`MM_BASE64_LO-1:`MM_BUS_LO]};
      end
      default: begin
        // reserved size select decodes nothing
        mm_hit = 1'b0;
      end
    endcase
    // a cleared enable or any I/O cycle never hits the window
    mm_hit = mm_hit && mmcfg_enable && !host_req.io;
  end

  // request from a window address, full 4 KB per function
  always_comb begin
    mm_cfg        = '0;
    mm_cfg.valid  = 1'b1;
    mm_cfg.write  = host_req.write;
    mm_cfg.bus    = mm_bus;
    mm_cfg.dev    = host_req.addr[`MM_DEV_HI:`MM_DEV_LO];
    mm_cfg.func   = host_req.addr[`MM_FUNC_HI:`MM_FUNC_LO];
    mm_cfg.ext    = host_req.addr[`MM_EXT_HI:`MM_EXT_LO];
    mm_cfg.regnum = host_req.addr[`MM_REG_HI:`MM_REG_LO];
    mm_cfg.be     = host_req.be;
    mm_cfg.wdata  = host_req.wdata;
  end

  // routing of the chosen request; both paths share one decision
  always_comb begin
    sel_cfg   = io_hit_data ? io_cfg : mm_cfg;
    sel_dest  = DEST_HUB;
    sel_abort = 1'b0;
    if (sel_cfg.bus == `BUS_ZERO) begin
      // bus zero: an internal device when present, else the hub
      if (sel_cfg.dev < `INT_DEV_LIMIT &&
          int_dev_enable[sel_cfg.dev[1:0]]) begin
        sel_dest = DEST_INT;
      end else begin
        // missing or disabled devices decode to the hub as type 0
        sel_dest = DEST_HUB;
      end
    end else if (sel_cfg.bus == gfx_secondary_bus) begin
      // only device 0 can sit directly behind the graphics port
      sel_dest  = DEST_GFX;
      sel_abort = sel_cfg.dev != `DEV_ZERO;
    end else if (sel_cfg.bus > gfx_secondary_bus &&
                 sel_cfg.bus <= gfx_subordinate_bus) begin
      // deeper buses behind the graphics bridge
      sel_dest      = DEST_GFX;
      sel_cfg.type1 = 1'b1;
    end else begin
      // any other bus number goes subtractively to the hub
      sel_dest      = DEST_HUB;
      sel_cfg.type1 = 1'b1;
    end
    // header bytes follow the final fields
    sel_cfg.hdr = build_hdr(sel_cfg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: next values

  cfg_cpl_type cpl;   // completion from the current destination

  // picks the completion of the target now in use
  // pulses from targets not in use are never looked at
  always_comb begin
    case (dest_r)
      DEST_INT: cpl = int_cpl;
      DEST_GFX: cpl = gfx_link_cpl;
      default:  cpl = hub_link_cpl;
    endcase
  end

  // a request is taken only while idle
  assign host_req_ready = (state_r == ST_IDLE);

  // computes the next index, request and answer
  always_comb begin
    state_nxt = state_r;
    index_nxt = index_r;
    creq_nxt  = creq_r;
    dest_nxt  = dest_r;
    rsp_nxt   = rsp_r;
    case (state_r)
      ST_IDLE: begin
        // nothing taken: answer fields fall back to zero
        rsp_nxt = '0;
        if (host_req.valid) begin
          state_nxt     = ST_DONE;
          // read value of a cycle that nobody answers
          rsp_nxt.rdata = `RDATA_FLOAT;
          if (io_dw_index) begin
            // index load or readback
            rsp_nxt.claimed = 1'b1;
            rsp_nxt.rdata   = index_r;
            if (host_req.write) begin
              index_nxt = host_req.wdata & `IDX_WMASK;
            end
          end else if (io_hit_data) begin
            // data window: translate through the current index
            rsp_nxt.claimed = 1'b1;
            if (index_r[`IDX_EN_BIT]) begin
              if (sel_abort) begin
                rsp_nxt.abort = 1'b1;
              end else begin
                creq_nxt  = sel_cfg;
                dest_nxt  = sel_dest;
                state_nxt = ST_WAIT;
              end
            end
            // enable clear: completes with no configuration cycle
          end else if (mm_hit) begin
            // memory window: translate straight from the address
            rsp_nxt.claimed = 1'b1;
            if (host_req.lock) begin
              // locked window cycles never reach a target
              rsp_nxt.abort = 1'b1;
            end else if (sel_abort) begin
              rsp_nxt.abort = 1'b1;
            end else begin
              creq_nxt  = sel_cfg;
              dest_nxt  = sel_dest;
              state_nxt = ST_WAIT;
            end
          end
          // anything else completes unclaimed
        end
      end
      ST_WAIT: begin
        // hold the request until its target completes
        if (cpl.valid) begin
          creq_nxt.valid = 1'b0;
          // a target abort floats the read data like a master abort
          rsp_nxt.abort  = cpl.abort;
          rsp_nxt.rdata  = cpl.abort ? `RDATA_FLOAT : cpl.rdata;
          state_nxt      = ST_DONE;
        end
      end
      ST_DONE: begin
        // answer already presented this cycle
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: registers

  // registers all sequencer state, synchronous active-low reset
  // reset leaves configuration access disabled in the index
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      index_r <= `IDX_RESET;
      creq_r  <= '0;
      dest_r  <= DEST_HUB;
      rsp_r   <= '0;
    end else begin
      state_r <= state_nxt;
      index_r <= index_nxt;
      creq_r  <= creq_nxt;
      dest_r  <= dest_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // answer flops, done strobed in the final state
  // done decodes the state so it can never outlive the answer
  always_comb begin
    host_rsp      = rsp_r;
    host_rsp.done = (state_r == ST_DONE);
  end

  // steer the held request to exactly one target
  // the fields are shared; only the chosen target sees valid
  always_comb begin
    int_req            = creq_r;
    hub_link_req       = creq_r;
    gfx_link_req       = creq_r;
    int_req.valid      = creq_r.valid && (dest_r == DEST_INT);
    hub_link_req.valid = creq_r.valid && (dest_r == DEST_HUB);
    gfx_link_req.valid = creq_r.valid && (dest_r == DEST_GFX);
  end

endmodule

`default_nettype wire

// ---- testbench/config_access_router_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// watches the router ports on the host and target sides
module config_access_router_properties
  import config_access_router_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_b,
  input wire host_req_type host_req,
  input wire logic         host_req_ready,
  input wire host_rsp_type host_rsp,
  input wire logic [7:0]   gfx_secondary_bus,
  input wire logic [7:0]   gfx_subordinate_bus,
  input wire logic [3:0]   int_dev_enable,
  input wire cfg_req_type  int_req,
  input wire cfg_req_type  hub_link_req,
  input wire cfg_cpl_type  hub_link_cpl,
  input wire cfg_req_type  gfx_link_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic take; // request accepted at this edge
  assign take = host_req.valid && host_req_ready;
  property p_idx_done;
    take && host_req.io && host_req.write && host_req.addr == 32'h0cf8
      && host_req.be == 4'hf |=> host_rsp.done && host_rsp.claimed;
  endproperty
  a_idx_done: assert property (p_idx_done) else $error("index write");
  property p_hdr_id;
    hub_link_req.valid |-> hub_link_req.hdr[31:16] ==
      {hub_link_req.bus, hub_link_req.dev, hub_link_req.func};
  endproperty
  a_hdr_id: assert property (p_hdr_id) else $error("header ids");
  property p_hdr_reg;
    gfx_link_req.valid |-> gfx_link_req.hdr[15:0] ==
      {4'h0, gfx_link_req.ext, gfx_link_req.regnum, 2'h0};
  endproperty
  a_hdr_reg: assert property (p_hdr_reg) else $error("header reg");
  property p_one_tgt;
    $onehot0({int_req.valid, hub_link_req.valid, gfx_link_req.valid});
  endproperty
  a_one_tgt: assert property (p_one_tgt) else $error("two targets");
  property p_int_claim;
    int_req.valid |-> int_req.bus == 8'h00 && int_req.dev < 5'h04
      && int_dev_enable[int_req.dev[1:0]];
  endproperty
  a_int_claim: assert property (p_int_claim) else $error("int");
  property p_gfx_t0;
    gfx_link_req.valid && gfx_link_req.bus == gfx_secondary_bus
      |-> !gfx_link_req.type1 && gfx_link_req.dev == 5'h00;
  endproperty
  a_gfx_t0: assert property (p_gfx_t0) else $error("gfx type 0");
  property p_gfx_t1;
    gfx_link_req.valid && gfx_link_req.bus != gfx_secondary_bus
      |-> gfx_link_req.type1 && gfx_link_req.bus > gfx_secondary_bus
      && gfx_link_req.bus <= gfx_subordinate_bus;
  endproperty
  a_gfx_t1: assert property (p_gfx_t1) else $error("gfx type 1");
  property p_hub_type;
    hub_link_req.valid |-> hub_link_req.type1 == (hub_link_req.bus != 0);
  endproperty
  a_hub_type: assert property (p_hub_type) else $error("hub type");
  property p_cpl_done;
    hub_link_req.valid && hub_link_cpl.valid
      |=> host_rsp.done && !hub_link_req.valid;
  endproperty
  a_cpl_done: assert property (p_cpl_done) else $error("no done");
  property p_hold;
    hub_link_req.valid && !hub_link_cpl.valid |=> $stable(hub_link_req);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
endmodule
bind config_access_router config_access_router_properties u_props (
  .clk(clk), .rst_b(rst_b), .host_req(host_req),
  .host_req_ready(host_req_ready), .host_rsp(host_rsp),
  .gfx_secondary_bus(gfx_secondary_bus),
  .gfx_subordinate_bus(gfx_subordinate_bus),
  .int_dev_enable(int_dev_enable), .int_req(int_req),
  .hub_link_req(hub_link_req), .hub_link_cpl(hub_link_cpl),
  .gfx_link_req(gfx_link_req));
`default_nettype wire

// ---- testbench/cfg_target_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// target: answers after 1..4 cycles, aborts register 3f
module cfg_target_model
  import config_access_router_pkg::*;
#(parameter logic [7:0] TAG = 8'h00)
(
  input  wire cfg_req_type req,
  input  wire logic        clk,
  output cfg_cpl_type      cpl
);
  logic [2:0]  cnt_r = 3'h0; // cycles the request has waited
  logic [31:0] d;            // answer names target and header
  always @(posedge clk) begin
    cnt_r <= (req.valid && !cpl.valid) ? cnt_r + 3'h1 : 3'h0;
  end
  assign d = {TAG, req.hdr[23:0]};
  // released data lines show the inverse, not the last value
  always_comb begin
    cpl.valid = req.valid && cnt_r == {1'b0, req.regnum[1:0]} + 3'h1;
    cpl.abort = req.regnum == 6'h3f;
    cpl.rdata = cpl.valid ? d : ~d;
  end
endmodule
`default_nettype wire

// ---- testbench/config_access_router_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module config_access_router_bench;
  import config_access_router_pkg::*;
  localparam logic [7:0]  SEC  = 8'h01;
  localparam logic [7:0]  SUB  = 8'h03;
  localparam logic [3:0]  EN   = 4'h7;
  localparam logic [31:0] BASE = 32'he000_0000;
  localparam logic [33:0] CA   = 34'h3_0000_0000;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         mmcfg_enable = 1'b1;
  logic [1:0]   mmcfg_size_sel = 2'h0;
  logic         host_req_ready;
  host_req_type host_req = '0;
  host_rsp_type host_rsp;
  cfg_req_type  int_req, hub_link_req, gfx_link_req;
  cfg_cpl_type  int_cpl, hub_link_cpl, gfx_link_cpl;
  logic [67:0]  notes[$]; // {mask, claimed abort rdata}
  logic [7:0]   bl[9] = '{8'h00, 8'h00, 8'h00, SEC, SEC, 8'h02, SUB,
                          8'h04, 8'hff};
  logic [4:0]   dl[5] = '{5'h00, 5'h03, 5'h05, 5'h00, 5'h02};
  int           n_mismatch = 0;
  int           n_tests = 0;
  int           cyc = 0;
  always #20 clk = ~clk;
  config_access_router u_config_access_router (.clk(clk), .rst_b(rst_b),
    .host_req(host_req), .host_req_ready(host_req_ready),
    .host_rsp(host_rsp), .mmcfg_enable(mmcfg_enable),
    .mmcfg_window_base(BASE[31:26]), .mmcfg_size_sel(mmcfg_size_sel),
    .gfx_secondary_bus(SEC), .gfx_subordinate_bus(SUB),
    .int_dev_enable(EN), .int_req(int_req), .int_cpl(int_cpl),
    .hub_link_req(hub_link_req), .hub_link_cpl(hub_link_cpl),
    .gfx_link_req(gfx_link_req), .gfx_link_cpl(gfx_link_cpl));
  cfg_target_model #(.TAG(8'h3c)) u_cfg_target_model_int (.clk(clk),
    .req(int_req), .cpl(int_cpl));
  cfg_target_model #(.TAG(8'h1a)) u_cfg_target_model_hub (.clk(clk),
    .req(hub_link_req), .cpl(hub_link_cpl));
  cfg_target_model #(.TAG(8'h2b)) u_cfg_target_model_gfx (.clk(clk),
    .req(gfx_link_req), .cpl(gfx_link_cpl));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // expected answer of a routed configuration read
  function automatic logic [33:0] ex(input logic [7:0] b,
    input logic [4:0] d, input logic [2:0] f, input logic [3:0] e,
    input logic [5:0] r);
    logic [7:0] t;
    t = 8'h1a;
    if (b == 8'h00 && d < 5'h04 && EN[d[1:0]]) t = 8'h3c;
    else if (b == SEC && d != 5'h00) return {2'b11, 32'hffff_ffff};
    else if (b >= SEC && b <= SUB) t = 8'h2b;
    return {2'b10, r == 6'h3f ? 32'hffff_ffff : {t, d, f, 4'h0, e, r, 2'h0}};
  endfunction
  // one host access, note kept for the monitor
  task automatic acc(input logic io, lk, wr, input logic [31:0] a, d,
                     input logic [3:0] be, input logic [33:0] v, m);
    int n;
    @(negedge clk);
    if (host_req_ready !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: not ready", $time);
    end
    host_req = {1'b1, io, wr, lk, a, be, d};
    notes.push_back({m, v});
    @(negedge clk);
    host_req.valid = 1'b0;
    n = 0;
    while (host_rsp.done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      n_mismatch++;
      $display("unexpected at %0t: no done", $time);
    end
  endtask
  task automatic idx(input logic [31:0] v);
    acc(1, 0, 1, 32'h0cf8, v, 4'hf, 34'h2_0000_0000, CA);
  endtask
  // monitor: oldest note against each completion
  always @(negedge clk) begin
    logic [67:0] nt;
    if (host_rsp.done === 1'b1) begin
      n_tests++;
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("unexpected at %0t: answer without request", $time);
      end else begin
        nt = notes.pop_front();
        if (({host_rsp.claimed, host_rsp.abort, host_rsp.rdata} & nt[67:34])
            !== (nt[33:0] & nt[67:34]) || notes.size() != 0) begin
          n_mismatch++;
          $display("unexpected at %0t: answer %h", $time, host_rsp);
        end
      end
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end
  initial begin
    logic [7:0] b;
    logic [4:0] dv;
    logic [2:0] f;
    logic [3:0] e;
    logic [5:0] r;
    logic [31:0] x;
    x = $urandom(13);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    x = $urandom;
    idx(x);
    acc(1, 0, 0, 32'h0cf8, 0, 4'hf, {2'b10, x & 32'h80ff_fffc}, '1);
    acc(1, 0, 1, 32'h0cf8, 0, 4'h1, 34'h0, 34'h2_0000_0000);
    acc(1, 0, 0, 32'h0cf8, 0, 4'hf, {2'b10, x & 32'h80ff_fffc}, '1);
    $display("test index done");
    idx(x & 32'h7fff_fffc);
    acc(1, 0, 0, 32'h0cfc, 0, 4'hf, {2'b10, 32'hffff_ffff}, '1);
    $display("test disabled done");
    for (int i = 0; i < 9; i++) begin
      b = bl[i];
      dv = i < 5 ? dl[i] : 5'($urandom);
      f = 3'($urandom);
      e = 4'($urandom);
      r = 6'($urandom) & 6'h3e;
      x = BASE + {4'h0, b, dv, f, e, r, 2'h0};
      idx({8'h80, b, dv, f, r, 2'h0});
      acc(1, 0, 0, 32'h0cfc, 0, 4'hf, ex(b, dv, f, 4'h0, r), '1);
      acc(1, 0, 1, 32'h0cfc, $urandom, 4'($urandom), ex(b, dv, f, 4'h0, r),
          CA);
      acc(0, 0, 0, x, 0, 4'hf, ex(b, dv, f, e, r), '1);
      acc(0, 0, 1, x, $urandom, 4'hf, ex(b, dv, f, e, r), CA);
    end
    $display("test routing done");
    acc(0, 1, 0, BASE, 0, 4'hf, CA, CA);
    idx({8'h80, 8'h04, 8'h00, 6'h3f, 2'h0});
    acc(1, 0, 0, 32'h0cfc, 0, 4'hf, '1, '1);
    mmcfg_size_sel = 2'h2;
    acc(0, 0, 0, BASE + 32'h0410_0000, 0, 4'hf, 34'h0, CA);
    acc(0, 0, 0, BASE + 32'h0010_0000, 0, 4'hf, ex(SEC, 0, 0, 0, 0), '1);
    mmcfg_size_sel = 2'h1;
    acc(0, 0, 0, BASE + 32'h0810_0000, 0, 4'hf, 34'h0, CA);
    mmcfg_size_sel = 2'h3;
    acc(0, 0, 0, BASE, 0, 4'hf, 34'h0, CA);
    mmcfg_size_sel = 2'h0;
    mmcfg_enable = 1'b0;
    acc(0, 0, 0, BASE, 0, 4'hf, 34'h0, CA);
    $display("test window done");
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    acc(1, 0, 0, 32'h0cf8, 0, 4'hf, 34'h2_0000_0000, '1);
    acc(1, 0, 0, 32'h0cfc, 0, 4'hf, {2'b10, 32'hffff_ffff}, '1);
    $display("test reset done");
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
